/* hdl/cam_pkg.sv */
// Purpose : Shared constants for the address map and fetch control block.
// Assumes : 16-bit byte addresses, 8-bit data.
// Notes   : Map offsets and the bank selector reset value live here.
package cam_pkg;
    // ****************************************************************
    // Address map
    // ****************************************************************
    localparam logic [15:0] ROM_END        = 16'hFFFF;    // Last ROM byte.
    localparam logic [15:0] ROM_BASE_8K    = 16'hE000;    // ROM start, 8K option.
    localparam logic [15:0] ROM_BASE_16K   = 16'hC000;    // ROM start, 16K option.
    localparam logic [15:0] RESET_VEC_HI   = 16'hFFFF;    // Reset vector high byte.
    localparam logic [15:0] RESET_VEC_LO   = 16'hFFFE;    // Reset vector low byte.
    localparam logic [15:0] INT_VEC_BASE   = 16'hFFE0;    // Interrupt vector table start.
    localparam logic [15:0] CALL_VEC_BASE  = 16'hFFC0;    // Vector call table start.
    localparam logic [15:0] CALL_VEC_END   = 16'hFFDF;    // Vector call table end.
    localparam logic [15:0] PAGE_BASE      = 16'hFF00;    // Page call entry page.
    localparam logic [15:0] PAGE_USE_END   = 16'hFFBF;    // Normal page call limit.
    localparam logic [15:0] RAM_BASE       = 16'h0040;    // First RAM byte.
    localparam logic [15:0] RAM_SIZE_256   = 16'h0100;    // RAM size options.
    localparam logic [15:0] RAM_SIZE_512   = 16'h0200;
    localparam logic [15:0] RAM_SIZE_1K    = 16'h0400;
    localparam logic [15:0] DIRECT_END     = 16'h00FF;    // Short direct window end.
    localparam logic [15:0] BANK_AREA_SIZE = 16'h0080;    // Register bank alias bytes.
    localparam logic [15:0] DBUF_BASE      = 16'h0F80;    // Data-buffer space start.
    localparam logic [15:0] DBUF_END       = 16'h0FFF;    // Data-buffer space end.
    localparam logic [15:0] PC_PREFETCH    = 16'h0002;    // Prefetch offset.
    localparam logic [3:0]  BANK_RESET     = 4'h0;        // Bank selector after reset.
    localparam logic [7:0]  UNDEF_READ     = 8'hFF;       // Read value of unmapped space.
    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        CAM_REG_ROM,
        CAM_REG_RAM,
        CAM_REG_SFS,
        CAM_REG_DBS
    } cam_region_e;
    typedef enum logic [2:0] {
        CAM_PC_NONE,
        CAM_PC_SEQ,
        CAM_PC_SHORT_REL,
        CAM_PC_LONG_REL,
        CAM_PC_ABS,
        CAM_PC_PC_PLUS_A,
        CAM_PC_TABLE_CALL,
        CAM_PC_PAGE_CALL
    } cam_pcop_e;
endpackage

/* hdl/cam_addr_fetch.sv */
// Purpose : Address decoding and program counter control for an 8-bit core.
// Assumes : One clock, clk_sys at 200 MHz; the fetch side keeps one op per cycle.
// Notes   : RAM is held in flip-flops; ROM is read through an external port.
module cam_addr_fetch #(
    parameter int          RAM_BYTES = 256,                 // RAM size option.
    parameter logic [15:0] ROM_BASE  = cam_pkg::ROM_BASE_8K // ROM start option.
) (
    input  wire logic        clk_sys,        // System clock.
    input  wire logic        arst_n,         // Asynchronous reset, active low.
    input  wire logic        pcop_valid,     // A program counter operation is offered.
    input  wire logic [2:0]  pcop_kind,      // Operation kind, cam_pcop_e coding.
    input  wire logic [7:0]  pcop_disp,      // Displacement, call number or page offset.
    input  wire logic [15:0] pcop_target,    // Absolute jump target.
    input  wire logic [7:0]  pcop_acc,       // Accumulator for PC plus A.
    input  wire logic [15:0] data_addr,      // Data access address.
    input  wire logic        data_rd,        // Data read strobe.
    input  wire logic        data_wr,        // Data write strobe.
    input  wire logic [7:0]  data_wdata,     // Data write value.
    output logic      [7:0]  data_rdata,     // Data read value, registered.
    input  wire logic        pcrel_rd,       // Table read at PC plus A.
    input  wire logic        bank_wr,        // Bank selector write strobe.
    input  wire logic [3:0]  bank_wdata,     // New bank selector.
    output logic      [3:0]  bank_sel,       // Current bank selector.
    output logic      [2:0]  bank_reg_idx,   // Register index inside current bank.
    output logic      [7:0]  bank_reg_data,  // Selected bank register, registered.
    output logic      [15:0] rom_addr,       // ROM read address.
    input  wire logic [7:0]  rom_data,       // ROM read data.
    output logic             sel_rom,        // Region select, ROM.
    output logic             sel_ram,        // Region select, RAM.
    output logic             sel_sfs,        // Region select, special function space.
    output logic             sel_dbs,        // Region select, data-buffer space.
    output logic             direct_ok,      // Address lies in short direct window.
    input  wire logic [7:0]  io_rdata,       // Peripheral read data.
    output logic      [15:0] pc,             // Visible program counter.
    output logic      [15:0] fetch_addr,     // Address of current instruction.
    output logic             boot_busy,      // Reset vector still being fetched.
    output logic             trap_rst_o,     // Reset pin output value, low on trap.
    output logic             trap_rst_oe     // Reset pin output enable.
);
    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic [1:0] rst_sync_q;                      // Reset release stages.
    logic       rst_n;                           // Synchronised reset.
    // Reset is released through two flops so deassertion is clean.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    localparam logic [15:0] RAM_LAST = 16'(cam_pkg::RAM_BASE + 16'(RAM_BYTES) - 16'h0001);
    localparam int          RAM_AW   = $clog2(RAM_BYTES);

    // ****************************************************************
    // Region decode
    // ****************************************************************
    // Classify one address; used for data access and fetch check alike.
    function automatic cam_pkg::cam_region_e region_of(input logic [15:0] a);
        if (a >= ROM_BASE) begin
            region_of = cam_pkg::CAM_REG_ROM;
        end else if (a >= cam_pkg::RAM_BASE && a <= RAM_LAST) begin
            region_of = cam_pkg::CAM_REG_RAM;
        end else if (a < cam_pkg::RAM_BASE) begin
            region_of = cam_pkg::CAM_REG_SFS;
        end else begin
            // Holes and the buffer area all go to the data-buffer space so
            // that one select is always active; unpopulated holes read undefined.
            region_of = cam_pkg::CAM_REG_DBS;
        end
    endfunction

    cam_pkg::cam_region_e data_region;           // Region of data_addr.
    logic                 dbs_hole;              // Unpopulated address.
    always_comb begin
        data_region = region_of(data_addr);
        sel_rom     = (data_region == cam_pkg::CAM_REG_ROM);
        sel_ram     = (data_region == cam_pkg::CAM_REG_RAM);
        sel_sfs     = (data_region == cam_pkg::CAM_REG_SFS);
        sel_dbs     = (data_region == cam_pkg::CAM_REG_DBS);
        dbs_hole    = sel_dbs && !(data_addr >= cam_pkg::DBUF_BASE &&
                                   data_addr <= cam_pkg::DBUF_END);
        direct_ok   = (data_addr <= cam_pkg::DIRECT_END);
    end

    // ****************************************************************
    // Program counter and fetch
    // ****************************************************************
    typedef enum logic [1:0] {
        CAM_BOOT_HI,
        CAM_BOOT_LO,
        CAM_RUN
    } cam_boot_e;

    cam_boot_e   boot_q,  boot_d;                // Reset vector fetch state.
    logic [15:0] pc_q,    pc_d;                  // Address of current instruction.
    logic [7:0]  vhi_q,   vhi_d;                 // Captured vector high byte.
    logic        trap_q,  trap_d;                // Address trap active.
    logic [15:0] pc_vis;                         // Prefetch-adjusted PC.
    logic [15:0] vec_addr;                       // Table vector address.

    assign pc_vis = 16'(pc_q + cam_pkg::PC_PREFETCH);

    // Next PC. All adds wrap in 16 bits: there is no page or bank limit.
    always_comb begin
        boot_d   = boot_q;
        pc_d     = pc_q;
        vhi_d    = vhi_q;
        trap_d   = 1'b0;
        vec_addr = 16'(cam_pkg::CALL_VEC_BASE + {11'h000, pcop_disp[3:0], 1'b0});
        rom_addr = data_addr;
        case (boot_q)
            CAM_BOOT_HI: begin
                rom_addr = cam_pkg::RESET_VEC_HI;
                vhi_d    = rom_data;
                boot_d   = CAM_BOOT_LO;
            end
            CAM_BOOT_LO: begin
                rom_addr = cam_pkg::RESET_VEC_LO;
                pc_d     = {vhi_q, rom_data};
                boot_d   = CAM_RUN;
            end
            default: begin
                if (pcrel_rd) begin
                    rom_addr = 16'(pc_vis + {8'h00, pcop_acc});
                end
                if (pcop_valid) begin
                    case (cam_pkg::cam_pcop_e'(pcop_kind))
                        cam_pkg::CAM_PC_SEQ:
                            pc_d = 16'(pc_q + 16'h0001);
                        cam_pkg::CAM_PC_SHORT_REL:
                            pc_d = 16'(pc_vis + {11'h000, pcop_disp[4:0]});
                        cam_pkg::CAM_PC_LONG_REL:
                            pc_d = 16'(pc_vis + {{8{pcop_disp[7]}}, pcop_disp});
                        cam_pkg::CAM_PC_ABS:
                            pc_d = pcop_target;
                        cam_pkg::CAM_PC_PC_PLUS_A:
                            pc_d = 16'(pc_vis + {8'h00, pcop_acc});
                        cam_pkg::CAM_PC_TABLE_CALL: begin
                            // Read the high byte of the little-endian call vector pair; the
                            // outside logic supplies the low byte as target.
                            rom_addr = 16'(vec_addr + 16'h0001);
                            pc_d     = {rom_data, pcop_target[7:0]};
                        end
                        cam_pkg::CAM_PC_PAGE_CALL:
                            pc_d = {cam_pkg::PAGE_BASE[15:8], pcop_disp};
                        default: ;
                    endcase
                end
                // Executing from RAM raises the address trap and restarts the vector fetch.
                if (region_of(pc_d) == cam_pkg::CAM_REG_RAM) begin
                    trap_d = 1'b1;
                    boot_d = CAM_BOOT_HI;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            boot_q <= CAM_BOOT_HI;
            pc_q   <= 16'h0000;
            vhi_q  <= 8'h00;
            trap_q <= 1'b0;
        end else begin
            boot_q <= boot_d;
            pc_q   <= pc_d;
            vhi_q  <= vhi_d;
            trap_q <= trap_d;
        end
    end

    assign pc          = pc_vis;
    assign fetch_addr  = pc_q;
    assign boot_busy   = (boot_q != CAM_RUN);
    assign trap_rst_o  = 1'b0;
    assign trap_rst_oe = trap_q;

    // ****************************************************************
    // Data RAM with register bank alias
    // ****************************************************************
    logic [7:0]        ram_q [RAM_BYTES];        // RAM storage.
    logic [RAM_AW-1:0] ram_idx;                  // RAM index of data_addr.
    logic [RAM_AW-1:0] bank_idx;                 // RAM index of bank register.
    logic [3:0]        bank_q, bank_d;           // Bank selector.
    logic [7:0]        rdata_q, rdata_d;         // Read data register.
    logic [7:0]        breg_q, breg_d;           // Bank register read register.

    // Bank registers share the RAM cells; no separate register file exists.
    always_comb begin
        ram_idx  = RAM_AW'(16'(data_addr - cam_pkg::RAM_BASE));
        bank_idx = RAM_AW'({bank_q, bank_reg_idx});
        bank_d   = bank_wr ? bank_wdata : bank_q;
        breg_d   = ram_q[bank_idx];
        if (!data_rd) begin
            rdata_d = rdata_q;
        end else if (sel_rom) begin
            rdata_d = rom_data;
        end else if (sel_ram) begin
            rdata_d = ram_q[ram_idx];
        end else if (dbs_hole) begin
            rdata_d = cam_pkg::UNDEF_READ;
        end else begin
            rdata_d = io_rdata;
        end
    end

    // Contents are not reset: RAM is undefined after power-up.
    always_ff @(posedge clk_sys) begin
        if (data_wr && sel_ram) begin
            ram_q[ram_idx] <= data_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bank_q  <= cam_pkg::BANK_RESET;
            rdata_q <= 8'h00;
            breg_q  <= 8'h00;
        end else begin
            bank_q  <= bank_d;
            rdata_q <= rdata_d;
            breg_q  <= breg_d;
        end
    end

    assign bank_reg_idx  = pcop_disp[2:0];
    assign bank_sel      = bank_q;
    assign bank_reg_data = breg_q;
    assign data_rdata    = rdata_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_boot_hi;
        boot_q == CAM_BOOT_HI;
    endsequence
    sequence s_boot_lo;
        boot_q == CAM_BOOT_LO;
    endsequence

    AST_ONE_SEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $onehot({sel_rom, sel_ram, sel_sfs, sel_dbs}))
        else $error("Region select not one-hot.");
    AST_PREFETCH: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pc == 16'(fetch_addr + 16'h0002))
        else $error("Visible PC is not fetch address plus two.");
    AST_BOOT_SEQ: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_boot_hi |=> s_boot_lo ##1 (boot_q == CAM_RUN))
        else $error("Reset vector fetch out of order.");
    AST_BOOT_PC: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_boot_lo |=> pc_q == {$past(vhi_q), $past(rom_data)})
        else $error("PC not loaded from reset vector.");
    AST_SHORT_REL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (boot_q == CAM_RUN && pcop_valid && pcop_kind == 3'(cam_pkg::CAM_PC_SHORT_REL)
         && region_of(pc_d) != cam_pkg::CAM_REG_RAM)
        |=> pc_q == 16'($past(pc_q) + 16'h0002 + {11'h000, $past(pcop_disp[4:0])}))
        else $error("Short relative target wrong.");
    AST_LONG_REL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (boot_q == CAM_RUN && pcop_valid && pcop_kind == 3'(cam_pkg::CAM_PC_LONG_REL)
         && region_of(pc_d) != cam_pkg::CAM_REG_RAM)
        |=> pc_q == 16'($past(pc_q) + 16'h0002 + {{8{$past(pcop_disp[7])}}, $past(pcop_disp)}))
        else $error("Long relative target wrong.");
    AST_TRAP: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (boot_q == CAM_RUN && region_of(pc_d) == cam_pkg::CAM_REG_RAM)
        |=> trap_rst_oe && !trap_rst_o ##1 s_boot_lo)
        else $error("Address trap not raised.");
    AST_BANK_RST: assert property (@(posedge clk_sys)
        $rose(rst_n) |-> bank_sel == cam_pkg::BANK_RESET)
        else $error("Bank selector not zero after reset.");
    AST_DIRECT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        direct_ok == (data_addr[15:8] == 8'h00))
        else $error("Direct window decode wrong.");
    // The trap drives the reset pin for exactly one cycle; the vector fetch restarts in that same cycle.
    AST_TRAP_ONCE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        trap_rst_oe |=> !trap_rst_oe)
        else $error("Address trap pulse longer than one cycle.");
    AST_BANK_WR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bank_wr |=> bank_sel == $past(bank_wdata))
        else $error("Bank selector did not take the written value.");
    AST_PAGE_CALL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (boot_q == CAM_RUN && pcop_valid && pcop_kind == 3'(cam_pkg::CAM_PC_PAGE_CALL))
        |=> fetch_addr == {8'hFF, $past(pcop_disp)})
        else $error("Page call target outside the top page.");
endmodule

/* verif/cam_tb_far.sv */
// Purpose : Stand-in for the ROM array and peripheral bus behind the block.
// Assumes : ROM and peripherals answer combinationally in the same cycle.
// Notes   : Contents follow a fixed pattern so the bench can predict any byte.
module cam_tb_far (
    input  wire logic [15:0] rom_addr,   // ROM read address from the block.
    input  wire logic [15:0] data_addr,  // Data address, used by the peripheral stand-in.
    output logic      [7:0]  rom_data,   // ROM byte at rom_addr.
    output logic      [7:0]  io_rdata    // Peripheral byte for the special spaces.
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // ROM contents
    // ****************************************************************
    localparam logic [7:0] VEC_HI = 8'hE8;  // Start address high byte, odd address.
    localparam logic [7:0] VEC_LO = 8'hC4;  // Start address low byte, even address.
    // Pattern byte for any ROM address; the bench predicts reads with it.
    function automatic logic [7:0] rom_byte(input logic [15:0] a);
        if (a == 16'hFFFF) return VEC_HI;
        if (a == 16'hFFFE) return VEC_LO;
        return a[7:0] ^ 8'hA5;
    endfunction
    // The array has no wait states, so the answer is purely combinational.
    always_comb rom_data = rom_byte(rom_addr);
    // Peripherals return a byte derived from the address so misrouting shows.
    always_comb io_rdata = data_addr[7:0] ^ 8'h3C;
endmodule

/* verif/cam_tb.sv */
// Purpose : Self-checking bench for the address map and fetch control block.
// Assumes : Inputs change at the falling edge; outputs are judged there too.
// Notes   : ROM bytes follow the partner's fixed pattern, so expected bytes are constants.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        clk_sys = 1'b0;  // System clock, 200 MHz.
    logic        arst_n  = 1'b0;  // Reset, held low at start.
    logic        pcop_valid = 1'b0, data_rd = 1'b0, data_wr = 1'b0;
    logic        pcrel_rd = 1'b0, bank_wr = 1'b0;
    logic [2:0]  pcop_kind = 3'h0;
    logic [7:0]  pcop_disp = 8'h00, pcop_acc = 8'h00, data_wdata = 8'h00;
    logic [15:0] pcop_target = 16'h0000, data_addr = 16'h0000;
    logic [3:0]  bank_wdata = 4'h0;
    logic [7:0]  data_rdata, bank_reg_data, rom_data, io_rdata;
    logic [3:0]  bank_sel;
    logic [2:0]  bank_reg_idx;
    logic [15:0] rom_addr, pc, fetch_addr;
    logic        sel_rom, sel_ram, sel_sfs, sel_dbs, direct_ok;
    logic        boot_busy, trap_rst_o, trap_rst_oe;
    int          err_total = 0;     // Mismatches seen.
    int          total_checks = 0;  // Comparisons made.
    always #2.5 clk_sys = ~clk_sys;
    cam_addr_fetch #(.RAM_BYTES(256), .ROM_BASE(16'hE000)) i_dut (.clk_sys(clk_sys),
        .arst_n(arst_n), .pcop_valid(pcop_valid), .pcop_kind(pcop_kind),
        .pcop_disp(pcop_disp), .pcop_target(pcop_target), .pcop_acc(pcop_acc),
        .data_addr(data_addr), .data_rd(data_rd), .data_wr(data_wr),
        .data_wdata(data_wdata), .data_rdata(data_rdata), .pcrel_rd(pcrel_rd),
        .bank_wr(bank_wr), .bank_wdata(bank_wdata), .bank_sel(bank_sel),
        .bank_reg_idx(bank_reg_idx), .bank_reg_data(bank_reg_data), .rom_addr(rom_addr),
        .rom_data(rom_data), .sel_rom(sel_rom), .sel_ram(sel_ram), .sel_sfs(sel_sfs),
        .sel_dbs(sel_dbs), .direct_ok(direct_ok), .io_rdata(io_rdata), .pc(pc),
        .fetch_addr(fetch_addr), .boot_busy(boot_busy), .trap_rst_o(trap_rst_o),
        .trap_rst_oe(trap_rst_oe));
    cam_tb_far i_rom (.rom_addr(rom_addr), .data_addr(data_addr), .rom_data(rom_data),
        .io_rdata(io_rdata));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // Single comparison point; four-state compare so an unknown never passes.
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        if (err_total == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Bounded wait for the vector fetch; a hang ends the run as a failure.
    task automatic wait_boot();
        for (int i = 0; i < 40; i++) begin
            if (boot_busy === 1'b0) return;
            @(negedge clk_sys);
        end
        err_total++;
        end_sim();
    endtask
    task automatic do_reset();
        arst_n = 1'b0;
        repeat (20) @(negedge clk_sys);
        arst_n = 1'b1;
        wait_boot();
    endtask
    // Offers one PC operation and leaves valid high, so calls run back to back.
    task automatic op(input cam_pkg::cam_pcop_e k, input logic [7:0] d,
                      input logic [15:0] t, input logic [15:0] exp);
        pcop_valid = 1'b1;
        pcop_kind = 3'(k);
        pcop_disp = d;
        pcop_target = t;
        @(negedge clk_sys);
        chk("fetch_addr", fetch_addr, exp);
        chk("pc", pc, exp + 16'h0002);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        data_wr = 1'b0;
        data_rd = 1'b1;
        data_addr = a;
        @(negedge clk_sys);
        chk("data_rdata", 16'(data_rdata), 16'(exp));
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        data_rd = 1'b0;
        data_wr = 1'b1;
        data_addr = a;
        data_wdata = v;
        @(negedge clk_sys);
    endtask
    task automatic idle();
        {pcop_valid, data_rd, data_wr, bank_wr, pcrel_rd} = 5'h00;
        @(negedge clk_sys);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Boot: start address comes from the top two ROM bytes, bank zero.
    task automatic t_boot();
        do_reset();
        chk("boot fetch", fetch_addr, 16'hE8C4);
        chk("boot pc", pc, 16'hE8C6);
        chk("boot bank", 16'(bank_sel), 16'h0000);
    endtask
    // Every jump kind back to back, including a wrap past FFFF.
    task automatic t_jumps();
        op(cam_pkg::CAM_PC_LONG_REL, 8'h80, 16'h0000, 16'hE846);
        op(cam_pkg::CAM_PC_SHORT_REL, 8'h1F, 16'h0000, 16'hE867);
        op(cam_pkg::CAM_PC_SEQ, 8'h00, 16'h0000, 16'hE868);
        op(cam_pkg::CAM_PC_ABS, 8'h00, 16'hC235, 16'hC235);
        op(cam_pkg::CAM_PC_ABS, 8'h00, 16'hFFFE, 16'hFFFE);
        op(cam_pkg::CAM_PC_SHORT_REL, 8'h04, 16'h0000, 16'h0004);
        op(cam_pkg::CAM_PC_TABLE_CALL, 8'h0F, 16'h0077, 16'h7A77);
        op(cam_pkg::CAM_PC_PAGE_CALL, 8'h40, 16'h0000, 16'hFF40);
        op(cam_pkg::CAM_PC_NONE, 8'h00, 16'h0000, 16'hFF40);
        pcop_acc = 8'h10;
        op(cam_pkg::CAM_PC_PC_PLUS_A, 8'h00, 16'h0000, 16'hFF52);
        idle();
    endtask
    // Decode table: {rom, ram, special, buffer, direct} at region edges.
    task automatic t_decode();
        logic [15:0] a[10] = '{16'h0000, 16'h003F, 16'h0040, 16'h00FF, 16'h0100,
                               16'h013F, 16'h0140, 16'hDFFF, 16'hE000, 16'hFFFF};
        logic [4:0]  e[10] = '{5'h05, 5'h05, 5'h09, 5'h09, 5'h08,
                               5'h08, 5'h02, 5'h02, 5'h10, 5'h10};
        for (int i = 0; i < 10; i++) begin
            data_addr = a[i];
            @(negedge clk_sys);
            chk("region", 16'({sel_rom, sel_ram, sel_sfs, sel_dbs, direct_ok}),
                16'(e[i]));
        end
        pcrel_rd = 1'b1;
        pcop_acc = 8'h10;
        @(negedge clk_sys);
        chk("pc plus a", rom_addr, 16'hFF64);
        idle();
    endtask
    // Bank aliasing, data reads of ROM, holes and peripherals, bank reset.
    task automatic t_ram();
        bank_wr = 1'b1;
        bank_wdata = 4'h3;
        pcop_disp = 8'h05;
        wr(16'h005D, 8'hA5);
        wr(16'h0500, 8'h11);
        rd(16'h005D, 8'hA5);
        rd(16'hF123, 8'h86);
        rd(16'h0500, cam_pkg::UNDEF_READ);
        rd(16'h0F80, 8'hBC);
        idle();
        chk("bank_sel", 16'(bank_sel), 16'h0003);
        chk("bank_reg", 16'(bank_reg_data), 16'h00A5);
        // Clearing RAM outside the current bank leaves the bank registers intact.
        wr(16'h0048, 8'h00);
        rd(16'h0048, 8'h00);
        chk("bank_reg kept", 16'(bank_reg_data), 16'h00A5);
        do_reset();
        chk("bank after reset", 16'(bank_sel), 16'h0000);
    endtask
    // Fetch just past RAM runs on; fetch at the last RAM byte traps once.
    task automatic t_trap();
        int n = 0;
        op(cam_pkg::CAM_PC_ABS, 8'h00, 16'h0140, 16'h0140);
        chk("no trap", 16'(trap_rst_oe), 16'h0000);
        op(cam_pkg::CAM_PC_ABS, 8'h00, 16'h013F, 16'h013F);
        pcop_valid = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (trap_rst_oe === 1'b1) begin
                n++;
                chk("trap level", 16'(trap_rst_o), 16'h0000);
            end
            @(negedge clk_sys);
        end
        chk("trap pulses", 16'(n), 16'h0001);
        wait_boot();
        chk("restart", fetch_addr, 16'hE8C4);
    endtask
    initial begin
        @(negedge clk_sys);
        t_boot();
        t_jumps();
        t_decode();
        t_ram();
        t_trap();
        end_sim();
    end
endmodule
